// >>> ahb_reg_port.sv
// Purpose: AHB-Lite slave that turns single word transfers into register strobes.
// Assumes: Only single word transfers; the response is always OKAY.
// Notes: Every transfer takes exactly one wait state.
`timescale 1ns/1ps
`default_nettype none
module ahb_reg_port (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // AHB-Lite slave side.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Register strobes.
  output logic bus_wr,
  output logic bus_rd,
  output logic [11:0] bus_addr,
  output logic [31:0] bus_wdata,
  input wire logic [31:0] bus_rdata
);

  can_mbc_pkg::bus_state_s r_r;
  can_mbc_pkg::bus_state_s r_nxt;
  logic unused_ok;

  always_comb begin
    r_nxt = r_r;
    case (r_r.st)
      can_mbc_pkg::AP_IDLE: begin
        r_nxt.hreadyout = 1'b1;
        if (hsel && htrans[1] && hready) begin
          r_nxt.st = can_mbc_pkg::AP_WAIT;
          r_nxt.addr = haddr[11:0];
          r_nxt.hit = (haddr[31:12] == 20'h00000);
          r_nxt.wr = hwrite;
          r_nxt.hreadyout = 1'b0;
        end
      end
      can_mbc_pkg::AP_WAIT: begin
        r_nxt.st = can_mbc_pkg::AP_IDLE;
        r_nxt.hreadyout = 1'b1;
        r_nxt.hrdata = (!r_r.wr && r_r.hit) ? bus_rdata : 32'h00000000;
      end
      default: begin
        r_nxt.st = can_mbc_pkg::AP_IDLE;
      end
    endcase
    if (!rstn) begin
      r_nxt = '0;
      r_nxt.hreadyout = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    r_r <= r_nxt;
  end

  assign bus_wr = (r_r.st == can_mbc_pkg::AP_WAIT) && r_r.wr && r_r.hit;
  assign bus_rd = (r_r.st == can_mbc_pkg::AP_WAIT) && !r_r.wr && r_r.hit;
  assign bus_addr = r_r.addr;
  assign bus_wdata = hwdata;
  assign hreadyout = r_r.hreadyout;
  assign hresp = 1'b0;
  assign hrdata = r_r.hrdata;
  assign unused_ok = ^hsize;

endmodule
`default_nettype wire

// >>> can_engine_model.sv
// Purpose: Frame engine partner that answers offered frames.
// Assumes: Shares the controller clock.
// Notes: Odd attempts lose arbitration, even attempts succeed.
`timescale 1ns/1ps
`default_nettype none
module can_engine_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Frame handshake.
  input wire logic tx_valid,
  output logic tx_done,
  output logic tx_lost
);
  logic [2:0] cnt_r;
  logic win_r;
  always_ff @(posedge clk) begin
    tx_done <= 1'b0;
    tx_lost <= 1'b0;
    if (!rstn || !tx_valid) cnt_r <= 3'h0;
    else if (cnt_r != 3'h7) cnt_r <= cnt_r + 3'h1;
    if (!rstn) win_r <= 1'b0;
    else if (tx_valid && cnt_r == 3'h2) begin
      tx_done <= win_r;
      tx_lost <= !win_r;
      win_r <= !win_r;
    end
  end
endmodule
`default_nettype wire

// >>> can_mbc_params.svh
// Purpose: Offsets, field positions and reset values of the CAN message buffer controller.
// Assumes: Registers are 32-bit words on a 12-bit byte address window.
// Notes: Definitions only.
`ifndef CAN_MBC_PARAMS_SVH
`define CAN_MBC_PARAMS_SVH

// Address map.
`define TX_BASE 12'h000
`define RX_BASE 12'h200
`define RX_END 12'h600
`define CFG_ADDR 12'h600
`define INT_ADDR 12'h604
`define STAT_ADDR 12'h608

// Transmit buffer control word.
`define TXC_REQ 0
`define TXC_ABORT 1
`define TXC_SST 2

// Receive buffer control word.
`define RXC_AVAIL 0
`define RXC_SENT 1
`define RXC_PEND 2
`define RXC_CANCEL 3
`define RXC_EN 4
`define RXC_IEN 5
`define RXC_AUTO 6
`define RXC_LINK 7

// Frame fields kept in both control words.
`define CTL_DLC_LSB 16
`define CTL_IDE 20
`define CTL_RTR 21

// Configuration and event status bits.
`define CFG_RUN 0
`define CFG_FIXED 1
`define INT_TXDONE 11
`define INT_RXDONE 12
`define INT_LOSS 13
`define INT_SSTF 14
`define INT_RTR 15

// Reset values.
`define CFG_RESET 2'h0
`define PIN_RESET 1'b1

`endif

// >>> can_mbc_pkg.sv
// Purpose: Types shared by the CAN message buffer controller files.
// Assumes: Nothing beyond the parameter header.
// Notes: Holds types only; numbers live in the header.
package can_mbc_pkg;

  typedef enum logic [0:0] {TX_IDLE, TX_BUSY} tx_state_e;
  typedef enum logic [0:0] {AP_IDLE, AP_WAIT} bus_state_e;

  typedef struct packed {
    logic [31:0][3:0][31:0] tx_mem;
    logic [31:0][7:0][31:0] rx_mem;
    logic [1:0] cfg;
    logic [31:0] int_st;
    logic [4:0] rr_ptr;
    tx_state_e st;
    logic cur_rtr;
    logic cur_sst;
    logic [4:0] cur_idx;
    logic tx_valid;
    logic [31:0] tx_id_word;
    logic [63:0] tx_data;
    logic [3:0] tx_dlc;
    logic tx_ide;
    logic tx_rtr;
    logic can_tx;
    logic tx_en_n;
    logic tx_en;
    logic engine_rx_bit;
  } can_state_s;

  typedef struct packed {
    bus_state_e st;
    logic [11:0] addr;
    logic wr;
    logic hit;
    logic hreadyout;
    logic [31:0] hrdata;
  } bus_state_s;

endpackage

// >>> can_message_buffer_controller.sv
// Purpose: Message buffer core of a CAN controller: 32 transmit and 32 receive buffers.
// Assumes: A frame-level protocol engine on the same clock does bit timing and errors.
// Notes: Registers are reached over AHB-Lite with one wait state.
// Operation
// - Driver-enable pin disables the transceiver while stopped or bus-off.
// - Pad enable is active low, fabric enable is active high.
// - Thirty-two transmit buffers; selection reruns after each send or loss.
// - Round-robin visits buffers 0 to 31 cyclically, only requested ones.
// - Fixed priority picks the lowest-numbered requested buffer first.
// - Pending remote replies go first, lowest receive buffer first.
// - Bit 0 is the request; software sets it, device holds it while pending.
// - A successful send clears the request and sets status bit 11.
// - Abort bit 1 holds until sent or removed.
// - Request plus abort together mean single-shot; cleared after a send.
// - Single-shot loss or error clears both flags and flags a failure.
// - Each frame scans receive buffers from 0 for enabled, matching ones.
// - Empty eligible buffer stores the frame, sets available, maybe flags receive.
// - Full eligible buffer without link drops the frame and flags loss.
// - Full linked buffer continues the search; none left means loss.
// - Extended identifier lands in bits 31:3, standard in bits 31:21.
// - Mask bit 0 compares with code, 1 ignores; any mismatch rejects.
// - Accepted remote frame with auto-reply sets pending instead of storing.
// - Sent reply sets a write-one-clear flag that raises the remote event when the buffer's interrupt enable is set.
// - The receive pin crosses into the message clock through a synchroniser.
//
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "can_mbc_params.svh"
module can_message_buffer_controller #(
  parameter int NUM_BUF = 32
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // AHB-Lite register bus.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Transceiver pins and fabric enable.
  input wire logic can_rx,
  output logic can_tx,
  output logic tx_en_n,
  output logic tx_en,
  // Protocol engine, bit level.
  output logic engine_rx_bit,
  input wire logic engine_tx_bit,
  input wire logic bus_off,
  // Protocol engine, received frame.
  input wire logic rx_valid,
  input wire logic [28:0] rx_id,
  input wire logic rx_ide,
  input wire logic rx_rtr,
  input wire logic [3:0] rx_dlc,
  input wire logic [63:0] rx_data,
  // Protocol engine, frame to send.
  output logic tx_valid,
  output logic [31:0] tx_id_word,
  output logic tx_ide,
  output logic tx_rtr,
  output logic [3:0] tx_dlc,
  output logic [63:0] tx_data,
  input wire logic tx_done,
  input wire logic tx_lost,
  input wire logic tx_error,
  // Event levels.
  output logic transmit_done_interrupt,
  output logic receive_done_interrupt,
  output logic receive_overrun_interrupt,
  output logic single_shot_fail_interrupt,
  output logic remote_reply_interrupt
);

  if (NUM_BUF != 32) begin : g_bad_size
    $error("The buffer count must be 32.");
  end

  can_mbc_pkg::can_state_s r_r;
  can_mbc_pkg::can_state_s r_nxt;
  logic bus_wr;
  logic bus_rd;
  logic [11:0] bus_addr;
  logic [31:0] bus_wdata;
  logic [31:0] bus_rdata;
  logic rx_level;
  logic [11:0] rx_off;
  logic [31:0] transmit_request_flag_vec;
  logic [31:0] rtr_pend_vec;
  logic rx_store;
  logic rx_loss;
  logic [4:0] rx_idx;
  logic sel_go;

  // Returns found flag and index of the first set bit at or after start, wrapping.
  function automatic logic [5:0] pick_first(input logic [31:0] v, input logic [4:0] start);
    logic [5:0] res;
    logic [4:0] k5;
    res = 6'h00;
    for (int k = 0; k < 32; k++) begin
      k5 = start + 5'(k);
      if (!res[5] && v[k5]) begin
        res = {1'b1, k5};
      end
    end
    return res;
  endfunction

  // True when every compared bit equals the code.
  function automatic logic filter_hit(input logic [31:0] in_w, input logic [31:0] code,
                                      input logic [31:0] mask);
    return ((in_w ^ code) & ~mask) == 32'h00000000;
  endfunction

  ahb_reg_port u_bus (
    .clk(clk),
    .rstn(rstn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .bus_wr(bus_wr),
    .bus_rd(bus_rd),
    .bus_addr(bus_addr),
    .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata)
  );

  // The receive pin is an asynchronous input.
  pin_sync u_rx_sync (
    .clk(clk),
    .rstn(rstn),
    .pin(can_rx),
    .level(rx_level)
  );

  assign rx_off = bus_addr - `RX_BASE;

  always_comb begin
    bus_rdata = 32'h00000000;
    if (bus_addr < `RX_BASE) begin
      bus_rdata = r_r.tx_mem[bus_addr[8:4]][bus_addr[3:2]];
    end else if (bus_addr < `RX_END) begin
      bus_rdata = r_r.rx_mem[rx_off[9:5]][rx_off[4:2]];
    end else if (bus_addr == `CFG_ADDR) begin
      bus_rdata = {30'h0, r_r.cfg};
    end else if (bus_addr == `INT_ADDR) begin
      bus_rdata = r_r.int_st;
    end else if (bus_addr == `STAT_ADDR) begin
      bus_rdata = {16'h0, 3'h0, r_r.cur_idx, 3'h0, r_r.rr_ptr};
      bus_rdata[31] = r_r.st == can_mbc_pkg::TX_BUSY;
      bus_rdata[30] = r_r.cur_rtr;
    end
  end

  always_comb begin
    logic [31:0] in_id;
    logic [31:0] in_dat;
    logic [31:0] c;
    logic [5:0] p;
    logic [4:0] i5;
    logic done_scan;
    logic seen;
    in_id = 32'h00000000;
    in_dat = 32'h00000000;
    c = 32'h00000000;
    p = 6'h00;
    i5 = 5'h00;
    done_scan = 1'b0;
    seen = 1'b0;
    r_nxt = r_r;
    rx_store = 1'b0;
    rx_loss = 1'b0;
    rx_idx = 5'h00;
    sel_go = 1'b0;

    // Register writes come first so that hardware events below win.
    if (bus_wr) begin
      if (bus_addr < `RX_BASE) begin
        if (bus_addr[3:2] == 2'h0) begin
          c = r_r.tx_mem[bus_addr[8:4]][0];
          c[31:3] = bus_wdata[31:3];
          // Setting both flags from idle marks a single-shot send.
          c[`TXC_SST] = c[`TXC_SST] |
                        (!c[`TXC_REQ] && bus_wdata[`TXC_REQ] && bus_wdata[`TXC_ABORT]);
          c[`TXC_REQ] = c[`TXC_REQ] | bus_wdata[`TXC_REQ];
          c[`TXC_ABORT] = c[`TXC_ABORT] | bus_wdata[`TXC_ABORT];
          r_nxt.tx_mem[bus_addr[8:4]][0] = c;
        end else begin
          r_nxt.tx_mem[bus_addr[8:4]][bus_addr[3:2]] = bus_wdata;
        end
      end else if (bus_addr < `RX_END) begin
        if (rx_off[4:2] == 3'h0) begin
          c = r_r.rx_mem[rx_off[9:5]][0];
          c[31:4] = bus_wdata[31:4];
          c[`RXC_CANCEL] = 1'b0;
          c[`RXC_PEND] = c[`RXC_PEND] & ~bus_wdata[`RXC_CANCEL];
          c[`RXC_SENT] = c[`RXC_SENT] & ~bus_wdata[`RXC_SENT];
          c[`RXC_AVAIL] = c[`RXC_AVAIL] & ~bus_wdata[`RXC_AVAIL];
          r_nxt.rx_mem[rx_off[9:5]][0] = c;
        end else begin
          r_nxt.rx_mem[rx_off[9:5]][rx_off[4:2]] = bus_wdata;
        end
      end else if (bus_addr == `CFG_ADDR) begin
        r_nxt.cfg = bus_wdata[1:0];
      end else if (bus_addr == `INT_ADDR) begin
        r_nxt.int_st = r_r.int_st & ~bus_wdata;
      end
    end

    // Transmit arbitration and completion.
    case (r_r.st)
      can_mbc_pkg::TX_IDLE: begin
        r_nxt.tx_valid = 1'b0;
        // A plain abort on an idle buffer removes the message.
        for (int i = 0; i < 32; i++) begin
          if (r_nxt.tx_mem[i][0][`TXC_ABORT] && !r_nxt.tx_mem[i][0][`TXC_SST]) begin
            r_nxt.tx_mem[i][0][`TXC_REQ] = 1'b0;
            r_nxt.tx_mem[i][0][`TXC_ABORT] = 1'b0;
          end
        end
        if (r_r.cfg[`CFG_RUN] && !bus_off) begin
          p = pick_first(rtr_pend_vec, 5'h00);
          if (p[5]) begin
            sel_go = 1'b1;
            r_nxt.cur_rtr = 1'b1;
            r_nxt.cur_sst = 1'b0;
            r_nxt.cur_idx = p[4:0];
            r_nxt.tx_id_word = r_r.rx_mem[p[4:0]][1];
            r_nxt.tx_data = {r_r.rx_mem[p[4:0]][3], r_r.rx_mem[p[4:0]][2]};
            c = r_r.rx_mem[p[4:0]][0];
          end else begin
            // Fixed priority starts at buffer 0, round-robin at the pointer.
            p = pick_first(transmit_request_flag_vec, r_r.cfg[`CFG_FIXED] ? 5'h00 : r_r.rr_ptr);
            if (p[5]) begin
              sel_go = 1'b1;
              r_nxt.cur_rtr = 1'b0;
              r_nxt.cur_sst = r_r.tx_mem[p[4:0]][0][`TXC_SST];
              r_nxt.cur_idx = p[4:0];
              r_nxt.tx_id_word = r_r.tx_mem[p[4:0]][1];
              r_nxt.tx_data = {r_r.tx_mem[p[4:0]][3], r_r.tx_mem[p[4:0]][2]};
              c = r_r.tx_mem[p[4:0]][0];
            end
          end
          if (sel_go) begin
            r_nxt.st = can_mbc_pkg::TX_BUSY;
            r_nxt.tx_valid = 1'b1;
            r_nxt.tx_dlc = c[`CTL_DLC_LSB +: 4];
            r_nxt.tx_ide = c[`CTL_IDE];
            r_nxt.tx_rtr = r_nxt.cur_rtr ? 1'b0 : c[`CTL_RTR];
          end
        end
      end
      can_mbc_pkg::TX_BUSY: begin
        i5 = r_r.cur_idx;
        if (tx_done) begin
          // Each finished frame sends the arbiter back to select again.
          r_nxt.st = can_mbc_pkg::TX_IDLE;
          r_nxt.tx_valid = 1'b0;
          if (r_r.cur_rtr) begin
            r_nxt.rx_mem[i5][0][`RXC_PEND] = 1'b0;
            r_nxt.rx_mem[i5][0][`RXC_SENT] = 1'b1;
          end else begin
            r_nxt.tx_mem[i5][0][`TXC_REQ] = 1'b0;
            r_nxt.tx_mem[i5][0][`TXC_ABORT] = 1'b0;
            r_nxt.tx_mem[i5][0][`TXC_SST] = 1'b0;
            r_nxt.int_st[`INT_TXDONE] = 1'b1;
            r_nxt.rr_ptr = i5 + 5'h01;
          end
        end else if (tx_lost || tx_error) begin
          r_nxt.st = can_mbc_pkg::TX_IDLE;
          r_nxt.tx_valid = 1'b0;
          if (!r_r.cur_rtr && r_r.cur_sst) begin
            r_nxt.tx_mem[i5][0][`TXC_REQ] = 1'b0;
            r_nxt.tx_mem[i5][0][`TXC_ABORT] = 1'b0;
            r_nxt.tx_mem[i5][0][`TXC_SST] = 1'b0;
            r_nxt.int_st[`INT_SSTF] = 1'b1;
          end
        end
      end
      default: begin
        r_nxt.st = can_mbc_pkg::TX_IDLE;
      end
    endcase

    // Receive scan, using the availability after this cycle's write.
    if (rx_valid) begin
      in_id = rx_ide ? {rx_id, 3'h0} : {rx_id[10:0], 21'h000000};
      in_id[2] = rx_ide;
      in_id[1] = rx_rtr;
      in_dat = {16'h0000, rx_data[15:0]};
      for (int i = 0; i < 32; i++) begin
        c = r_nxt.rx_mem[i][0];
        if (!done_scan && c[`RXC_EN] &&
            filter_hit(in_id, r_r.rx_mem[i][5], r_r.rx_mem[i][4]) &&
            filter_hit(in_dat, r_r.rx_mem[i][7],
                       r_r.rx_mem[i][6] | 32'hFFFF0000)) begin
          seen = 1'b1;
          if (rx_rtr && c[`RXC_AUTO]) begin
            done_scan = 1'b1;
            r_nxt.rx_mem[i][0][`RXC_PEND] = 1'b1;
          end else if (!c[`RXC_AVAIL]) begin
            done_scan = 1'b1;
            rx_store = 1'b1;
            rx_idx = 5'(i);
          end else if (!c[`RXC_LINK]) begin
            done_scan = 1'b1;
            rx_loss = 1'b1;
          end
        end
      end
      rx_loss = rx_loss || (seen && !done_scan);
      if (rx_store) begin
        c = r_nxt.rx_mem[rx_idx][0];
        c[`RXC_AVAIL] = 1'b1;
        c[`CTL_DLC_LSB +: 4] = rx_dlc;
        c[`CTL_IDE] = rx_ide;
        c[`CTL_RTR] = rx_rtr;
        r_nxt.rx_mem[rx_idx][0] = c;
        r_nxt.rx_mem[rx_idx][1] = {in_id[31:3], 3'h0};
        r_nxt.rx_mem[rx_idx][2] = rx_data[31:0];
        r_nxt.rx_mem[rx_idx][3] = rx_data[63:32];
        if (c[`RXC_IEN]) begin
          r_nxt.int_st[`INT_RXDONE] = 1'b1;
        end
      end
      if (rx_loss) begin
        r_nxt.int_st[`INT_LOSS] = 1'b1;
      end
    end

    // Disabling a buffer drops its pending reply; the remote event is a level.
    r_nxt.int_st[`INT_RTR] = 1'b0;
    for (int i = 0; i < 32; i++) begin
      if (!r_nxt.rx_mem[i][0][`RXC_EN]) begin
        r_nxt.rx_mem[i][0][`RXC_PEND] = 1'b0;
      end
      if (r_nxt.rx_mem[i][0][`RXC_SENT] && r_nxt.rx_mem[i][0][`RXC_IEN]) begin
        r_nxt.int_st[`INT_RTR] = 1'b1;
      end
    end

    // Pins and the transceiver enable.
    r_nxt.tx_en_n = !r_r.cfg[`CFG_RUN] || bus_off;
    r_nxt.tx_en = r_r.cfg[`CFG_RUN] && !bus_off;
    r_nxt.can_tx = engine_tx_bit || !r_nxt.tx_en;
    r_nxt.engine_rx_bit = rx_level;

    if (!rstn) begin
      r_nxt = '0;
      r_nxt.cfg = `CFG_RESET;
      r_nxt.tx_en_n = `PIN_RESET;
      r_nxt.can_tx = `PIN_RESET;
      r_nxt.engine_rx_bit = `PIN_RESET;
    end
  end

  always_ff @(posedge clk) begin
    r_r <= r_nxt;
  end

  always_comb begin
    for (int i = 0; i < 32; i++) begin
      transmit_request_flag_vec[i] = r_r.tx_mem[i][0][`TXC_REQ] &&
                     !(r_r.tx_mem[i][0][`TXC_ABORT] && !r_r.tx_mem[i][0][`TXC_SST]);
      rtr_pend_vec[i] = r_r.rx_mem[i][0][`RXC_PEND];
    end
  end

  assign can_tx = r_r.can_tx;
  assign tx_en_n = r_r.tx_en_n;
  assign tx_en = r_r.tx_en;
  assign engine_rx_bit = r_r.engine_rx_bit;
  assign tx_valid = r_r.tx_valid;
  assign tx_id_word = r_r.tx_id_word;
  assign tx_ide = r_r.tx_ide;
  assign tx_rtr = r_r.tx_rtr;
  assign tx_dlc = r_r.tx_dlc;
  assign tx_data = r_r.tx_data;
  assign transmit_done_interrupt = r_r.int_st[`INT_TXDONE];
  assign receive_done_interrupt = r_r.int_st[`INT_RXDONE];
  assign receive_overrun_interrupt = r_r.int_st[`INT_LOSS];
  assign single_shot_fail_interrupt = r_r.int_st[`INT_SSTF];
  assign remote_reply_interrupt = r_r.int_st[`INT_RTR];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_pins_opposite: assert property (tx_en_n == !tx_en)
    else $error("Pad and fabric enables disagree.");
  a_stop_disables: assert property ((!r_r.cfg[`CFG_RUN] || bus_off) |=> tx_en_n)
    else $error("Transceiver left enabled while stopped or bus-off.");
  a_done_clears_req: assert property ((r_r.st == can_mbc_pkg::TX_BUSY && tx_done
    && !r_r.cur_rtr)
    |=> (!r_r.tx_mem[$past(r_r.cur_idx)][0][`TXC_REQ] && transmit_done_interrupt))
    else $error("Send completion did not clear request or set status.");
  a_sst_fail: assert property ((r_r.st == can_mbc_pkg::TX_BUSY && !tx_done && tx_lost
    && r_r.cur_sst && !r_r.cur_rtr) |=> (single_shot_fail_interrupt
    && !r_r.tx_mem[$past(r_r.cur_idx)][0][`TXC_ABORT]))
    else $error("Single-shot failure not reported.");
  a_fixed_lowest: assert property (($rose(tx_valid) && !r_r.cur_rtr
    && r_r.cfg[`CFG_FIXED])
    |-> (($past(transmit_request_flag_vec) & ((32'h00000001 << r_r.cur_idx) - 32'h00000001)) == 32'h0))
    else $error("Fixed priority skipped a lower buffer.");
  a_reply_first: assert property (($rose(tx_valid) && !r_r.cur_rtr)
    |-> ($past(rtr_pend_vec) == 32'h00000000))
    else $error("Data frame sent before a pending reply.");
  a_rx_stored: assert property ((rx_valid && rx_store)
    |=> r_r.rx_mem[$past(rx_idx)][0][`RXC_AVAIL])
    else $error("Accepted frame not marked available.");
  a_rx_loss: assert property ((rx_valid && rx_loss) |=> receive_overrun_interrupt[*2])
    else $error("Dropped frame not flagged.");

  c_tx_done: cover property (tx_valid ##[1:20] tx_done);
  c_rx_store: cover property (rx_valid && rx_store);
  c_reply_sent: cover property (tx_valid && r_r.cur_rtr && tx_done);
  c_sst_fail: cover property (tx_valid && r_r.cur_sst && tx_lost);

endmodule
`default_nettype wire

// >>> can_message_buffer_controller_test.sv
// Purpose: Self-checking bench of the CAN message buffer controller.
// Assumes: Register transfers finish when hreadyout is seen high.
// Notes: Identifiers come from a fixed-seed xorshift.
`timescale 1ns/1ps
`default_nettype none
`include "can_mbc_params.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
  $display("BAD %0t %h %h", $time, a, b); end end
module can_message_buffer_controller_test;
  logic clk, rstn, hwrite, hreadyout, can_rx, bus_off, rx_valid, tx_valid, tx_en_n, tx_en;
  logic tx_done, tx_lost, txd_irq, rxd_irq, ovr_irq, ssf_irq, ide;
  logic [3:0] dlc;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, tx_id_word, q, id_a, id_b, seed, e;
  logic [28:0] rid;
  logic [63:0] rx_data;
  int fail_count, tests_run;
  can_message_buffer_controller u_can_message_buffer_controller (.clk, .rstn,
    .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hreadyout, .hresp(), .hrdata, .can_rx, .can_tx(), .tx_en_n, .tx_en,
    .engine_rx_bit(), .engine_tx_bit(1'b1), .bus_off, .rx_valid, .rx_id(rid),
    .rx_ide(ide), .rx_rtr(1'b0), .rx_dlc(dlc), .rx_data, .tx_valid, .tx_id_word,
    .tx_ide(), .tx_rtr(), .tx_dlc(), .tx_data(), .tx_done, .tx_lost, .tx_error(1'b0),
    .transmit_done_interrupt(txd_irq), .receive_done_interrupt(rxd_irq),
    .receive_overrun_interrupt(ovr_irq), .single_shot_fail_interrupt(ssf_irq),
    .remote_reply_interrupt());
  can_engine_model u_can_engine_model (.clk, .rstn, .tx_valid, .tx_done, .tx_lost);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] idw(input logic [28:0] i, input logic x);
    return x ? {i, 3'h0} : {i[10:0], 21'h000000};
  endfunction
  task automatic conclude();
    $display("counts run %0d bad %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    q = hrdata;
    if (n >= 50) begin fail_count++; conclude(); end
  endtask
  task automatic wait_tx(input logic v);
    int n;
    n = 0;
    while (tx_valid !== v && n < 100) begin @(posedge clk); n++; end
    if (n >= 100) begin fail_count++; conclude(); end
  endtask
  task automatic frame();
    e = rnd();
    rid <= e[28:0];
    ide <= e[31];
    dlc <= e[30:27];
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    {rstn, hwrite, bus_off, rx_valid, htrans, haddr, hwdata, rid, dlc, ide} = '0;
    {fail_count, tests_run} = '0;
    can_rx = 1'b1;
    seed = 32'h00011781;
    rx_data = {rnd(), rnd()};
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    `CHK({tx_en_n, tx_en}, 2'h2)
    id_a = rnd();
    id_b = rnd();
    xfer(1'b1, 32'h54, id_a);
    xfer(1'b1, 32'h24, id_b);
    xfer(1'b1, 32'h50, 32'h1);
    xfer(1'b1, 32'h20, 32'h1);
    xfer(1'b1, `CFG_ADDR, 32'h3);
    for (int k = 0; k < 4; k++) begin
      wait_tx(1'b1);
      `CHK(tx_id_word, (k < 2) ? id_b : id_a)
      wait_tx(1'b0);
    end
    `CHK({tx_en_n, tx_en}, 2'h1)
    xfer(1'b0, 32'h20, 32'h0);
    `CHK(q[0], 1'b0)
    xfer(1'b0, `INT_ADDR, 32'h0);
    `CHK(q[11], 1'b1)
    `CHK(txd_irq, 1'b1)
    $display("test transmit done");
    xfer(1'b1, `CFG_ADDR, 32'h0);
    xfer(1'b1, 32'h70, 32'h1);
    xfer(1'b1, 32'h20, 32'h1);
    `CHK({tx_en_n, tx_en}, 2'h2)
    xfer(1'b1, `CFG_ADDR, 32'h1);
    for (int k = 0; k < 4; k++) begin
      wait_tx(1'b1);
      `CHK(tx_id_word, (k < 2) ? 32'h0 : id_b)
      wait_tx(1'b0);
    end
    xfer(1'b1, 32'h30, 32'h3);
    wait_tx(1'b1);
    wait_tx(1'b0);
    xfer(1'b0, 32'h30, 32'h0);
    `CHK(q[2:0], 3'h0)
    `CHK({ssf_irq, tx_valid}, 2'h2)
    $display("test arbitration done");
    xfer(1'b1, 32'h210, 32'hFFFFFFFF);
    xfer(1'b1, 32'h218, 32'h0000FFFF);
    xfer(1'b1, 32'h200, 32'h00000030);
    frame();
    e = idw(rid, ide);
    xfer(1'b0, 32'h204, 32'h0);
    `CHK(q[31:3], e[31:3])
    xfer(1'b0, 32'h200, 32'h0);
    `CHK(q[0], 1'b1)
    `CHK(q[20:16], {ide, dlc})
    `CHK(rxd_irq, 1'b1)
    frame();
    `CHK(ovr_irq, 1'b1)
    xfer(1'b1, 32'h230, 32'hFFFFFFFF);
    xfer(1'b1, 32'h238, 32'h0000FFFF);
    xfer(1'b1, 32'h220, 32'h00000010);
    xfer(1'b1, 32'h200, 32'h000000B0);
    frame();
    xfer(1'b0, 32'h220, 32'h0);
    `CHK(q[0], 1'b1)
    xfer(1'b1, 32'h200, 32'h00000031);
    xfer(1'b0, 32'h200, 32'h0);
    `CHK(q[0], 1'b0)
    xfer(1'b0, 32'h700, 32'h0);
    `CHK(q, 32'h0)
    $display("test receive done");
    bus_off <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(tx_en_n, 1'b1)
    $display("test bus off done");
    conclude();
  end
endmodule
`default_nettype wire

// >>> pin_sync.sv
// Purpose: Brings an asynchronous pin into the clock domain.
// Assumes: The pin is stable for at least three clock periods per level.
// Notes: The output moves only once the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
`include "can_mbc_params.svh"
module pin_sync (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Pin and synchronised level.
  input wire logic pin,
  output logic level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_s;

  sync_s r_r;
  sync_s r_nxt;

  always_comb begin
    r_nxt = r_r;
    r_nxt.s1 = pin;
    r_nxt.s2 = r_r.s1;
    r_nxt.s3 = r_r.s2;
    if (r_r.s2 == r_r.s3) begin
      r_nxt.lvl = r_r.s3;
    end
    if (!rstn) begin
      r_nxt = {4{`PIN_RESET}};
    end
  end

  always_ff @(posedge clk) begin
    r_r <= r_nxt;
  end

  assign level = r_r.lvl;

endmodule
`default_nettype wire
